// File: hw/oag_top.sv
`timescale 1ns/1ps
`default_nettype none

module oag_top (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] index_i,
    input wire oag_pkg::oag_byte_s fetch_i,
    input wire logic cond_i,
    input wire logic test_valid_i,
    input wire logic [7:0] test_data_i,
    output logic fetch_req_o,
    output logic [15:0] fetch_addr_o,
    output logic test_req_o,
    output logic [15:0] test_addr_o,
    output oag_pkg::oag_result_s result_o,
    output logic carry_we_o,
    output logic carry_o,
    output logic busy_o
);

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic helpers

    function automatic logic [15:0] rel_target(input logic [15:0] next_pc,
                                               input logic [7:0] off);
        logic [15:0] ext;
        ext = {{8{off[oag_pkg::OFF_SIGN_BIT]}}, off};
        rel_target = next_pc + ext;
    endfunction : rel_target

    function automatic logic [15:0] page_zero(input logic [7:0] low);
        page_zero = {oag_pkg::PAGE_ZERO, low};
    endfunction : page_zero

    ////////////////////////////////////////////////////////////////////////
    // Decode and state

    oag_pkg::oag_state_e state_q;
    oag_pkg::oag_mode_e mode_q;
    oag_pkg::oag_mode_e dec_mode;
    logic [1:0] dec_len;
    logic dec_bitbr;
    logic [1:0] len_q;
    logic bitbr_q;
    logic [7:0] opc_q;
    logic [7:0] op1_q;
    logic [15:0] pc_q;
    logic [15:0] addr_q;

    oag_mode_decode u_dec (
        .opcode_i(fetch_i.data),
        .mode_o(dec_mode),
        .length_o(dec_len),
        .bit_branch_o(dec_bitbr)
    );

    logic [15:0] next_pc;
    assign next_pc = pc_q + {14'h0000, len_q};

    logic bit_val;
    assign bit_val = test_data_i[opc_q[3:1]];

    // Tested byte stands only in its answer cycle, so decide from the held carry
    // Bit-set branch has an even row, bit-clear an odd row
    logic bit_cond;
    assign bit_cond = opc_q[0] ? ~carry_o : carry_o;

    logic [8:0] ix1_sum;
    assign ix1_sum = {1'b0, index_i} + {1'b0, fetch_i.data};

    logic [15:0] ix2_sum;
    assign ix2_sum = {op1_q, fetch_i.data} + {8'h00, index_i};

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= oag_pkg::OAG_ST_OPC;
            mode_q <= oag_pkg::OAG_MODE_INH;
            len_q <= oag_pkg::LEN_ONE;
            bitbr_q <= 1'b0;
            opc_q <= 8'h00;
            op1_q <= 8'h00;
            pc_q <= 16'h0000;
            addr_q <= 16'h0000;
        end else begin
            case (state_q)
                oag_pkg::OAG_ST_OPC: begin
                    if (fetch_i.valid && busy_o) begin
                        opc_q <= fetch_i.data;
                        mode_q <= dec_mode;
                        len_q <= dec_len;
                        bitbr_q <= dec_bitbr;
                        if (dec_len == oag_pkg::LEN_ONE) begin
                            state_q <= oag_pkg::OAG_ST_DONE;
                            if (dec_mode == oag_pkg::OAG_MODE_IX) begin
                                addr_q <= page_zero(index_i);
                            end else begin
                                addr_q <= 16'h0000;
                            end
                        end else begin
                            state_q <= oag_pkg::OAG_ST_OP1;
                        end
                    end else if (start_i && !busy_o) begin
                        pc_q <= pc_i;
                    end
                end
                oag_pkg::OAG_ST_OP1: begin
                    if (fetch_i.valid) begin
                        op1_q <= fetch_i.data;
                        case (mode_q)
                            oag_pkg::OAG_MODE_DIR: begin
                                addr_q <= page_zero(fetch_i.data);
                            end
                            oag_pkg::OAG_MODE_IX1: begin
                                addr_q <= {7'h00, ix1_sum};
                            end
                            default: begin
                                addr_q <= 16'h0000;
                            end
                        endcase
                        if (len_q == oag_pkg::LEN_THREE) begin
                            state_q <= oag_pkg::OAG_ST_OP2;
                        end else begin
                            state_q <= oag_pkg::OAG_ST_DONE;
                        end
                    end
                end
                oag_pkg::OAG_ST_OP2: begin
                    if (fetch_i.valid) begin
                        op1_q <= bitbr_q ? fetch_i.data : op1_q;
                        case (mode_q)
                            oag_pkg::OAG_MODE_EXT: begin
                                addr_q <= {op1_q, fetch_i.data};
                            end
                            oag_pkg::OAG_MODE_IX2: begin
                                addr_q <= ix2_sum;
                            end
                            default: begin
                                addr_q <= addr_q;
                            end
                        endcase
                        state_q <= bitbr_q ? oag_pkg::OAG_ST_TEST : oag_pkg::OAG_ST_DONE;
                    end
                end
                oag_pkg::OAG_ST_TEST: begin
                    if (test_valid_i) begin
                        state_q <= oag_pkg::OAG_ST_DONE;
                    end
                end
                oag_pkg::OAG_ST_DONE: begin
                    state_q <= oag_pkg::OAG_ST_OPC;
                    pc_q <= next_pc;
                end
                default: begin
                    state_q <= oag_pkg::OAG_ST_OPC;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Busy: armed by start, ends as the result is issued

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_o <= 1'b0;
        end else if (state_q == oag_pkg::OAG_ST_DONE) begin
            busy_o <= 1'b0;
        end else if (start_i && state_q == oag_pkg::OAG_ST_OPC) begin
            busy_o <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction fetch address

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fetch_req_o <= 1'b0;
            fetch_addr_o <= 16'h0000;
        end else if (start_i && !busy_o && state_q == oag_pkg::OAG_ST_OPC) begin
            fetch_req_o <= 1'b1;
            fetch_addr_o <= pc_i;
        end else if (fetch_i.valid && fetch_req_o) begin
            if ((state_q == oag_pkg::OAG_ST_OPC && dec_len != oag_pkg::LEN_ONE) ||
                (state_q == oag_pkg::OAG_ST_OP1 && len_q == oag_pkg::LEN_THREE)) begin
                fetch_addr_o <= fetch_addr_o + 16'h0001;
            end else begin
                fetch_req_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tested location read for the bit branches

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            test_req_o <= 1'b0;
            test_addr_o <= 16'h0000;
        end else if (state_q == oag_pkg::OAG_ST_OP2 && fetch_i.valid && bitbr_q) begin
            test_req_o <= 1'b1;
            test_addr_o <= addr_q;
        end else if (test_valid_i) begin
            test_req_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result and carry

    logic taken;
    always_comb begin
        taken = 1'b0;
        if (mode_q == oag_pkg::OAG_MODE_REL) begin
            taken = cond_i;
        end else if (bitbr_q) begin
            taken = bit_cond;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            result_o <= '0;
            carry_we_o <= 1'b0;
            carry_o <= 1'b0;
        end else begin
            result_o.valid <= 1'b0;
            carry_we_o <= 1'b0;
            if (state_q == oag_pkg::OAG_ST_TEST && test_valid_i) begin
                carry_we_o <= 1'b1;
                carry_o <= bit_val;
            end
            if (state_q == oag_pkg::OAG_ST_DONE) begin
                result_o.valid <= 1'b1;
                result_o.mode <= mode_q;
                result_o.length <= len_q;
                result_o.bit_branch <= bitbr_q;
                result_o.is_branch <= (mode_q == oag_pkg::OAG_MODE_REL) || bitbr_q;
                result_o.ea_valid <= !(mode_q == oag_pkg::OAG_MODE_INH ||
                                       mode_q == oag_pkg::OAG_MODE_IMM ||
                                       mode_q == oag_pkg::OAG_MODE_REL);
                result_o.ea <= addr_q;
                result_o.imm <= (mode_q == oag_pkg::OAG_MODE_IMM) ? op1_q : 8'h00;
                if (taken) begin
                    result_o.next_pc <= rel_target(next_pc, op1_q);
                end else begin
                    result_o.next_pc <= next_pc;
                end
            end
        end
    end

endmodule : oag_top

`default_nettype wire

// File: hw/oag_pkg.sv
package oag_pkg;

    // Operand field bytes and instruction lengths
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;
    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam int OFF_SIGN_BIT = 7;

    // Opcode map: column nibble selects the mode
    localparam logic [3:0] COL_BITBR = 4'h0;
    localparam logic [3:0] COL_REL = 4'h2;
    localparam logic [3:0] COL_DIR_RMW = 4'h3;
    localparam logic [3:0] COL_INH_A = 4'h4;
    localparam logic [3:0] COL_INH_X = 4'h5;
    localparam logic [3:0] COL_IX1_RMW = 4'h6;
    localparam logic [3:0] COL_IX_RMW = 4'h7;
    localparam logic [3:0] COL_INH_8 = 4'h8;
    localparam logic [3:0] COL_INH_9 = 4'h9;
    localparam logic [3:0] COL_IMM = 4'ha;
    localparam logic [3:0] COL_DIR = 4'hb;
    localparam logic [3:0] COL_EXT = 4'hc;
    localparam logic [3:0] COL_IX2 = 4'hd;
    localparam logic [3:0] COL_IX1 = 4'he;
    localparam logic [3:0] COL_IX = 4'hf;
    localparam logic [3:0] ROW_BSR = 4'hd;

    typedef enum logic [7:0] {
        OAG_MODE_INH = 8'h01,
        OAG_MODE_IMM = 8'h02,
        OAG_MODE_DIR = 8'h04,
        OAG_MODE_EXT = 8'h08,
        OAG_MODE_IX = 8'h10,
        OAG_MODE_IX1 = 8'h20,
        OAG_MODE_IX2 = 8'h40,
        OAG_MODE_REL = 8'h80
    } oag_mode_e;

    typedef enum logic [4:0] {
        OAG_ST_OPC = 5'h01,
        OAG_ST_OP1 = 5'h02,
        OAG_ST_OP2 = 5'h04,
        OAG_ST_TEST = 5'h08,
        OAG_ST_DONE = 5'h10
    } oag_state_e;

    // One fetched instruction byte from the program stream
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } oag_byte_s;

    // Result of address generation for one instruction
    typedef struct packed {
        logic valid;
        oag_mode_e mode;
        logic [1:0] length;
        logic ea_valid;
        logic [15:0] ea;
        logic [7:0] imm;
        logic is_branch;
        logic bit_branch;
        logic [15:0] next_pc;
    } oag_result_s;

endpackage : oag_pkg

// File: hw/oag_mode_decode.sv
`timescale 1ns/1ps
`default_nettype none

module oag_mode_decode (
    input wire logic [7:0] opcode_i,
    output oag_pkg::oag_mode_e mode_o,
    output logic [1:0] length_o,
    output logic bit_branch_o
);

    logic [3:0] col;
    assign col = opcode_i[7:4];

    always_comb begin
        bit_branch_o = 1'b0;
        mode_o = oag_pkg::OAG_MODE_INH;
        length_o = oag_pkg::LEN_ONE;
        case (col)
            oag_pkg::COL_BITBR: begin
                mode_o = oag_pkg::OAG_MODE_DIR;
                length_o = oag_pkg::LEN_THREE;
                bit_branch_o = 1'b1;
            end
            oag_pkg::COL_REL: begin
                mode_o = oag_pkg::OAG_MODE_REL;
                length_o = oag_pkg::LEN_TWO;
            end
            oag_pkg::COL_DIR_RMW, oag_pkg::COL_DIR: begin
                mode_o = oag_pkg::OAG_MODE_DIR;
                length_o = oag_pkg::LEN_TWO;
            end
            oag_pkg::COL_INH_A, oag_pkg::COL_INH_X, oag_pkg::COL_INH_8,
            oag_pkg::COL_INH_9: begin
                mode_o = oag_pkg::OAG_MODE_INH;
                length_o = oag_pkg::LEN_ONE;
            end
            oag_pkg::COL_IMM: begin
                // Branch to subroutine sits in the immediate column
                if (opcode_i[3:0] == oag_pkg::ROW_BSR) begin
                    mode_o = oag_pkg::OAG_MODE_REL;
                end else begin
                    mode_o = oag_pkg::OAG_MODE_IMM;
                end
                length_o = oag_pkg::LEN_TWO;
            end
            oag_pkg::COL_EXT: begin
                mode_o = oag_pkg::OAG_MODE_EXT;
                length_o = oag_pkg::LEN_THREE;
            end
            oag_pkg::COL_IX2: begin
                mode_o = oag_pkg::OAG_MODE_IX2;
                length_o = oag_pkg::LEN_THREE;
            end
            oag_pkg::COL_IX1, oag_pkg::COL_IX1_RMW: begin
                mode_o = oag_pkg::OAG_MODE_IX1;
                length_o = oag_pkg::LEN_TWO;
            end
            oag_pkg::COL_IX, oag_pkg::COL_IX_RMW: begin
                mode_o = oag_pkg::OAG_MODE_IX;
                length_o = oag_pkg::LEN_ONE;
            end
            default: begin
                mode_o = oag_pkg::OAG_MODE_INH;
                length_o = oag_pkg::LEN_ONE;
            end
        endcase
    end

endmodule : oag_mode_decode

`default_nettype wire

// File: bench/oag_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module oag_mem_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic slow_i,
    input wire logic fetch_req_i,
    input wire logic [15:0] fetch_addr_i,
    output oag_pkg::oag_byte_s fetch_o,
    input wire logic test_req_i,
    input wire logic [15:0] test_addr_i,
    output logic test_valid_o,
    output logic [7:0] test_data_o
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_q;
    logic served_q;

    ////////////////////////////////////////////////////////////////
    // Program bytes: one every other cycle while requested (every fourth when slow), idle data toggles
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fetch_o <= '0;
            wait_q <= 2'h0;
        end else if (fetch_req_i && !fetch_o.valid && wait_q == 2'h0) begin
            fetch_o <= {1'b1, mem[fetch_addr_i]};
            wait_q <= {slow_i, slow_i};
        end else begin
            fetch_o <= {1'b0, ~fetch_o.data};
            if (wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Tested location: answered once per request
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            test_valid_o <= 1'b0;
            test_data_o <= 8'h00;
            served_q <= 1'b0;
        end else if (test_req_i && !served_q) begin
            test_valid_o <= 1'b1;
            test_data_o <= mem[test_addr_i];
            served_q <= 1'b1;
        end else begin
            test_valid_o <= 1'b0;
            test_data_o <= ~test_data_o;
            served_q <= served_q && test_req_i;
        end
    end
endmodule : oag_mem_model

`default_nettype wire

// File: bench/oag_top_properties.sv
`timescale 1ns/1ps
`default_nettype none

module oag_checker (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] index_i,
    input wire oag_pkg::oag_byte_s fetch_i,
    input wire logic cond_i,
    input wire logic test_valid_i,
    input wire logic [7:0] test_data_i,
    input wire logic fetch_req_o,
    input wire logic [15:0] fetch_addr_o,
    input wire logic test_req_o,
    input wire logic [15:0] test_addr_o,
    input wire oag_pkg::oag_result_s result_o,
    input wire logic carry_we_o,
    input wire logic carry_o,
    input wire logic busy_o
);
    logic [15:0] pc_q;
    logic [7:0] opc_q;
    logic [7:0] m;
    logic v;
    assign m = result_o.mode;
    assign v = result_o.valid;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_q <= 16'h0000;
        end else if (start_i && !busy_o) begin
            pc_q <= pc_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            opc_q <= 8'h00;
        end else if (fetch_req_o && fetch_i.valid && fetch_addr_o == pc_q) begin
            opc_q <= fetch_i.data;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_take; start_i && !busy_o; endsequence
    sequence s_test; test_req_o && test_valid_i; endsequence

    property p_start; s_take |=> fetch_req_o && fetch_addr_o == $past(pc_i); endproperty
    a_start: assert property (p_start) else $error("fetch not at start pc");
    property p_step; fetch_req_o && fetch_i.valid
        |=> fetch_req_o ? fetch_addr_o == $past(fetch_addr_o) + 16'h1 : $stable(fetch_addr_o);
    endproperty
    a_step: assert property (p_step) else $error("fetch address not stepped");
    property p_inh; v && m == 8'h01 |-> result_o.length == 2'h1 && !result_o.ea_valid; endproperty
    a_inh: assert property (p_inh) else $error("inherent result wrong");
    property p_imm; v && m == 8'h02 |-> result_o.length == 2'h2 && !result_o.ea_valid; endproperty
    a_imm: assert property (p_imm) else $error("immediate result wrong");
    property p_dir; v && m == 8'h04 && !result_o.bit_branch |-> result_o.ea[15:8] == 8'h00;
    endproperty
    a_dir: assert property (p_dir) else $error("direct high byte not zero");
    property p_ext; v && m == 8'h08 |-> result_o.length == 2'h3 && result_o.ea_valid; endproperty
    a_ext: assert property (p_ext) else $error("extended result wrong");
    property p_ix; v && m == 8'h10 |-> result_o.ea == {8'h00, index_i}; endproperty
    a_ix: assert property (p_ix) else $error("indexed address wrong");
    property p_ix1; v && m == 8'h20 |-> result_o.ea <= 16'h01fe && result_o.ea >= {8'h00, index_i};
    endproperty
    a_ix1: assert property (p_ix1) else $error("indexed offset address out of range");
    property p_rel; v && result_o.is_branch && !result_o.bit_branch && !cond_i
        |-> result_o.next_pc == pc_q + 16'h2; endproperty
    a_rel: assert property (p_rel) else $error("untaken branch target wrong");
    property p_carry; s_test |=> carry_we_o && carry_o == $past(test_data_i[opc_q[3:1]]);
    endproperty
    a_carry: assert property (p_carry) else $error("tested bit not copied");
    property p_taddr; test_req_o |-> test_addr_o[15:8] == 8'h00; endproperty
    a_taddr: assert property (p_taddr) else $error("tested address not in page zero");
endmodule : oag_checker

bind oag_top oag_checker u_oag_checker (.clk_i, .rstn_i, .start_i, .pc_i, .index_i, .fetch_i,
    .cond_i, .test_valid_i, .test_data_i, .fetch_req_o, .fetch_addr_o, .test_req_o,
    .test_addr_o, .result_o, .carry_we_o, .carry_o, .busy_o);

`default_nettype wire

// File: bench/oag_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module oag_top_tb_top;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic start_i = 1'b0;
    logic [15:0] pc_i = 16'h0000;
    logic [7:0] index_i = 8'h00;
    logic cond_i = 1'b0;
    logic slow_i = 1'b0;
    oag_pkg::oag_byte_s fetch_i;
    logic test_valid_i, fetch_req_o, test_req_o, carry_we_o, carry_o, busy_o, carry_seen;
    logic [7:0] test_data_i;
    logic [15:0] fetch_addr_o, test_addr_o, taddr;
    oag_pkg::oag_result_s result_o, res;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    int carries = 0;

    always #5 clk_i = ~clk_i;

    oag_top u_oag_top (.clk_i, .rstn_i, .start_i, .pc_i, .index_i, .fetch_i, .cond_i,
        .test_valid_i, .test_data_i, .fetch_req_o, .fetch_addr_o, .test_req_o, .test_addr_o,
        .result_o, .carry_we_o, .carry_o, .busy_o);
    oag_mem_model u_oag_mem_model (.clk_i, .rstn_i, .slow_i, .fetch_req_i(fetch_req_o),
        .fetch_addr_i(fetch_addr_o), .fetch_o(fetch_i), .test_req_i(test_req_o),
        .test_addr_i(test_addr_o), .test_valid_o(test_valid_i), .test_data_o(test_data_i));

    always @(negedge clk_i) begin
        if (carry_we_o === 1'b1) begin
            carries++;
            carry_seen = carry_o;
        end
        if (test_req_o === 1'b1) begin
            taddr = test_addr_o;
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic run(input logic [15:0] pc, input logic [7:0] b0, b1, b2);
        int n;
        u_oag_mem_model.mem[pc] = b0;
        u_oag_mem_model.mem[pc + 16'h1] = b1;
        u_oag_mem_model.mem[pc + 16'h2] = b2;
        pc_i = pc;
        start_i = 1'b1;
        @(posedge clk_i);
        #1 start_i = 1'b0;
        n = 0;
        while (result_o.valid !== 1'b1 && n < 60) begin
            @(posedge clk_i);
            #1 n++;
        end
        res = result_o;
        chk({15'h0, result_o.valid}, 16'h1);
        @(posedge clk_i);
        #1;
    endtask : run

    task automatic want(input logic [7:0] m, input logic [1:0] n, input logic e,
        input logic [15:0] a, input logic [15:0] p);
        chk({8'h00, res.mode}, {8'h00, m});
        chk({14'h0, res.length}, {14'h0, n});
        chk({15'h0, res.ea_valid}, {15'h0, e});
        chk(res.ea, a);
        chk(res.next_pc, p);
    endtask : want

    ////////////////////////////////////////////////////////////////
    task automatic t_plain();
        run(16'h0100, 8'h4c, 8'h00, 8'h00);
        want(8'h01, 2'h1, 1'b0, 16'h0000, 16'h0101);
        run(16'h0200, 8'ha6, 8'h5a, 8'h00);
        want(8'h02, 2'h2, 1'b0, 16'h0000, 16'h0202);
        chk({8'h00, res.imm}, 16'h005a);
        run(16'h0300, 8'hb6, 8'h80, 8'h00);
        want(8'h04, 2'h2, 1'b1, 16'h0080, 16'h0302);
        slow_i = 1'b1;
        run(16'h0400, 8'hc6, 8'h12, 8'h34);
        want(8'h08, 2'h3, 1'b1, 16'h1234, 16'h0403);
        slow_i = 1'b0;
    endtask : t_plain

    task automatic t_indexed();
        index_i = 8'hff;
        run(16'h0500, 8'hf6, 8'h00, 8'h00);
        want(8'h10, 2'h1, 1'b1, 16'h00ff, 16'h0501);
        run(16'h0510, 8'he6, 8'hff, 8'h00);
        want(8'h20, 2'h2, 1'b1, 16'h01fe, 16'h0512);
        index_i = 8'h20;
        run(16'h0520, 8'hd6, 8'hff, 8'hf0);
        want(8'h40, 2'h3, 1'b1, 16'h0010, 16'h0523);
    endtask : t_indexed

    task automatic t_relative();
        cond_i = 1'b1;
        run(16'h0600, 8'h20, 8'h80, 8'h00);
        chk(res.next_pc, 16'h0582);
        run(16'h0610, 8'h20, 8'h7f, 8'h00);
        chk(res.next_pc, 16'h0691);
        run(16'h0630, 8'had, 8'h04, 8'h00);
        want(8'h80, 2'h2, 1'b0, 16'h0000, 16'h0636);
        cond_i = 1'b0;
        run(16'h0620, 8'h20, 8'h80, 8'h00);
        chk(res.next_pc, 16'h0622);
        chk({15'h0, res.is_branch}, 16'h1);
    endtask : t_relative

    task automatic t_bit_branch();
        u_oag_mem_model.mem[16'h0040] = 8'h02;
        carries = 0;
        run(16'h0700, 8'h02, 8'h40, 8'h10);
        chk(res.next_pc, 16'h0713);
        chk({14'h0, res.length}, 16'h0003);
        chk({15'h0, res.bit_branch}, 16'h0001);
        chk(taddr, 16'h0040);
        chk({15'h0, carry_seen}, 16'h0001);
        slow_i = 1'b1;
        run(16'h0800, 8'h03, 8'h40, 8'h10);
        slow_i = 1'b0;
        chk(res.next_pc, 16'h0803);
        chk(carries[15:0], 16'h0002);
    endtask : t_bit_branch

    initial begin
        repeat (3) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        t_plain();
        t_indexed();
        t_relative();
        t_bit_branch();
        print_verdict();
    end
endmodule : oag_top_tb_top

`default_nettype wire
